//--- include/asc_regs.svh
// Purpose: register indices, field positions and reset values of the sequence control
// Assumes: byte address on the bus is four times the register index
// Notes:   definitions only
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define ASC_IDX_CTL3    6'h03
`define ASC_IDX_MODE    6'h04
`define ASC_IDX_START   6'h05
`define ASC_IDX_STAT0   6'h06
`define ASC_IDX_CMP     6'h09
`define ASC_IDX_CCF     6'h0A
`define ASC_IDX_IRQ_ST  6'h0C
`define ASC_IDX_IRQ_MSK 6'h0D
`define ASC_IDX_RES_HI  3'h2

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define ASC_RES_MAX     8
`define ASC_CTL3_RST    8'h20
`define ASC_DJM_BIT     7
`define ASC_LEN_MSB     6
`define ASC_LEN_LSB     3
`define ASC_FIFO_BIT    2
`define ASC_FRZ_MSB     1
`define ASC_FRZ_LSB     0
`define ASC_FRZ_FINISH  2'h2
`define ASC_FRZ_STOP    2'h3
`define ASC_MODE_SCAN   0
`define ASC_MODE_MULT   1
`define ASC_MODE_EXT_TRIGGER_MODE_ENABLE 2
`define ASC_CMP_IE_BIT  8
`define ASC_IRQ_SEQ     0
`define ASC_IRQ_OVR     1

`endif

//--- include/asc_pkg.sv
// Purpose: types of the sequence control
// Assumes: asc_regs.svh on the include path
// Notes:   result file sized for the largest supported depth
`include "asc_regs.svh"
package asc_pkg;

  typedef enum logic [2:0] {ASC_IDLE, ASC_ARMED, ASC_ISSUE, ASC_BUSY, ASC_HALT} asc_state_t;

  typedef struct packed {
    logic                              ack;
    logic [31:0]                       rdata;
    asc_state_t                        state;
    logic [7:0]                        ctl3;
    logic [2:0]                        mode;
    logic [3:0]                        start_ch;
    logic                              cmp_ie;
    logic [7:0]                        cmp_en;
    logic [7:0]                        ccf;
    logic [1:0]                        irq_st;
    logic [1:0]                        irq_msk;
    logic [`ASC_RES_MAX-1:0][15:0]     res;
    logic [3:0]                        seq_idx;
    logic                              stop_pend;
    logic                              stop_d;
    logic                              conv_start;
    logic                              conv_abort;
    logic [3:0]                        chan;
    logic                              trig_s1;
    logic                              trig_s2;
    logic                              trig_s3;
    logic                              trig_lvl;
  } asc_ctrl_t;

  typedef struct packed {
    logic [3:0] count;
  } asc_cnt_t;

endpackage

//--- src/asc_slot_counter.sv
// Purpose: result slot counter, names the result register for the next result
// Assumes: limit between 1 and 16
// Notes:   clear beats advance
`timescale 1ns/1ps
module asc_slot_counter (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       clear,
  input  wire logic       advance,
  input  wire logic [4:0] limit,
  output logic      [3:0] count
);

  asc_pkg::asc_cnt_t cnt_r;
  asc_pkg::asc_cnt_t cnt_nxt;

  // ----------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    if (clear) begin
      cnt_nxt.count = 4'h0;
    end else if (advance) begin
      if ({1'b0, cnt_r.count} >= limit - 5'h01) begin
        cnt_nxt.count = 4'h0;
      end else begin
        cnt_nxt.count = cnt_r.count + 4'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r.count;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_clear_zero: assert property (@(posedge clock) disable iff (sys_rst)
    clear |=> count == 4'h0)
    else $error("slot counter not cleared");

  a_slot_wrap: assert property (@(posedge clock) disable iff (sys_rst)
    advance && !clear && ({1'b0, count} == limit - 5'h01) |=> count == 4'h0)
    else $error("slot counter did not wrap");

  a_slot_step: assert property (@(posedge clock) disable iff (sys_rst)
    advance && !clear && ({1'b0, count} < limit - 5'h01) |=> count == $past(count) + 4'h1)
    else $error("slot counter did not step");

endmodule

//--- src/asc_seq_control.sv
// Purpose: sequence control of a 10-bit converter behind an Avalon-MM slave
// Assumes: converter core and mode inputs share the bus clock; trigger is a pin
// Notes:   one wait cycle on every bus access
// Function
// - single or continuous, one or many channels
// - stop aborts; exit restarts, clearing flags
// - run and wait behave the same
// - freeze: continue, finish or stop
// - control three write aborts the sequence
// - bit 7 picks left or right justify
// - bits 6-3 length, reset length four
// - non-FIFO: result lands by sequence position
// - FIFO: counter kept across sequences
// - FIFO scanning wraps at result file end
// - status zero shows the slot counter
// - abort or start clears the slot counter
// - FIFO disables automatic compare
// - bits 1-0 hold the freeze response
// - start write begins sequence, clears flags
// - external trigger: start write only arms
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_seq_control #(
  parameter int RES_DEPTH = `ASC_RES_MAX
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        stop_mode,
  input  wire logic        freeze_mode,
  input  wire logic        ext_trigger,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_result,
  output logic             conv_start,
  output logic             conv_abort,
  output logic      [3:0]  conv_channel,
  output logic             cmp_irq_en_eff,
  output logic      [7:0]  cmp_en_eff,
  output logic             irq
);

  generate
    if (RES_DEPTH < 2 || RES_DEPTH > `ASC_RES_MAX) begin : g_bad_depth
      $error("RES_DEPTH out of range");
    end
  endgenerate

  localparam asc_pkg::asc_ctrl_t CTRL_RST = '{ctl3: `ASC_CTL3_RST, state: asc_pkg::ASC_IDLE, default: '0};
  localparam logic [4:0] DEPTH5 = 5'(RES_DEPTH);

  asc_pkg::asc_ctrl_t st_r;
  asc_pkg::asc_ctrl_t st_nxt;
  logic [3:0]  slot;
  logic [4:0]  seq_len;
  logic [4:0]  slot_lim;
  logic [31:0] rd_word;
  logic [5:0]  idx;
  logic        acc_wr;
  logic        acc_rd;
  logic        wr_lo;
  logic        wr_ctl3;
  logic        wr_start;
  logic        fifo;
  logic        scan;
  logic        mult;
  logic        ext_trigger_mode_enable;
  logic [1:0]  frz;
  logic        frz_stop_now;
  logic        trig_rise;
  logic        stop_rise;
  logic        stop_fall;
  logic        abort;
  logic        restart;
  logic        store;
  logic        last;
  logic        seq_begin;
  logic        slot_clr;
  logic [1:0]  irq_ev;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // zero or a length above the result file runs the whole file
  function automatic logic [4:0] seq_len_of(input logic [7:0] ctl3);
    logic [3:0] n;
    n = ctl3[`ASC_LEN_MSB:`ASC_LEN_LSB];
    if (n == 4'h0 || {1'b0, n} > DEPTH5) begin
      seq_len_of = DEPTH5;
    end else begin
      seq_len_of = {1'b0, n};
    end
  endfunction

  function automatic logic [15:0] justify(input logic [9:0] d, input logic right);
    justify = right ? {6'h00, d} : {d, 6'h00};
  endfunction

  // ----------------------------------------------------------------
  // bus access and events
  // ----------------------------------------------------------------
  assign idx             = avs_address[7:2];
  assign avs_waitrequest = ~st_r.ack;
  assign acc_wr          = avs_write & st_r.ack;
  assign acc_rd          = avs_read & st_r.ack;
  assign wr_lo           = acc_wr & avs_byteenable[0];
  assign wr_ctl3         = wr_lo & (idx == `ASC_IDX_CTL3);
  assign wr_start        = wr_lo & (idx == `ASC_IDX_START);

  assign fifo   = st_r.ctl3[`ASC_FIFO_BIT];
  assign frz    = st_r.ctl3[`ASC_FRZ_MSB:`ASC_FRZ_LSB];
  assign scan   = st_r.mode[`ASC_MODE_SCAN];
  assign mult   = st_r.mode[`ASC_MODE_MULT];
  assign ext_trigger_mode_enable = st_r.mode[`ASC_MODE_EXT_TRIGGER_MODE_ENABLE];

  assign seq_len      = seq_len_of(st_r.ctl3);
  assign frz_stop_now = freeze_mode & (frz == `ASC_FRZ_STOP);
  // a new level counts only once the two late stages agree
  assign trig_rise    = st_r.trig_s2 & st_r.trig_s3 & ~st_r.trig_lvl;
  assign stop_rise    = stop_mode & ~st_r.stop_d;
  assign stop_fall    = ~stop_mode & st_r.stop_d;
  assign abort        = wr_ctl3 | stop_rise;
  assign restart      = (wr_start & ~stop_mode) | (stop_fall & st_r.stop_pend);
  assign store        = (st_r.state == asc_pkg::ASC_BUSY) & conv_done & ~frz_stop_now;
  assign last         = store & ({1'b0, st_r.seq_idx} == seq_len - 5'h01);
  assign seq_begin    = ((st_r.state == asc_pkg::ASC_ARMED) & trig_rise) | (last & scan & ~ext_trigger_mode_enable);
  // in FIFO mode only abort or start resets the slot
  assign slot_clr     = restart | abort | (seq_begin & ~fifo);
  assign slot_lim     = fifo ? DEPTH5 : seq_len;

  assign irq_ev[`ASC_IRQ_SEQ] = last;
  assign irq_ev[`ASC_IRQ_OVR] = ext_trigger_mode_enable & trig_rise & (st_r.state inside
                                {asc_pkg::ASC_ISSUE, asc_pkg::ASC_BUSY, asc_pkg::ASC_HALT});

  asc_slot_counter u_slot (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clear   (slot_clr),
    .advance (store),
    .limit   (slot_lim),
    .count   (slot)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (idx)
      `ASC_IDX_CTL3:    rd_word = {24'h000000, st_r.ctl3};
      `ASC_IDX_MODE:    rd_word = {29'h00000000, st_r.mode};
      `ASC_IDX_START:   rd_word = {28'h0000000, st_r.start_ch};
      `ASC_IDX_STAT0:   rd_word = {23'h000000, st_r.state != asc_pkg::ASC_IDLE, 4'h0, slot};
      `ASC_IDX_CMP:     rd_word = {23'h000000, st_r.cmp_ie, st_r.cmp_en};
      `ASC_IDX_CCF:     rd_word = {24'h000000, st_r.ccf};
      `ASC_IDX_IRQ_ST:  rd_word = {30'h00000000, st_r.irq_st};
      `ASC_IDX_IRQ_MSK: rd_word = {30'h00000000, st_r.irq_msk};
      default: begin
        if (idx[5:3] == `ASC_IDX_RES_HI && {2'h0, idx[2:0]} < DEPTH5) begin
          rd_word = {16'h0000, st_r.res[idx[2:0]]};
        end else begin
          rd_word = 32'h00000000;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt            = st_r;
    st_nxt.ack        = (avs_read | avs_write) & ~st_r.ack;
    st_nxt.conv_start = 1'b0;
    st_nxt.conv_abort = 1'b0;
    st_nxt.stop_d     = stop_mode;
    st_nxt.trig_s1    = ext_trigger;
    st_nxt.trig_s2    = st_r.trig_s1;
    st_nxt.trig_s3    = st_r.trig_s2;
    if (st_r.trig_s2 == st_r.trig_s3) begin
      st_nxt.trig_lvl = st_r.trig_s3;
    end
    if (avs_read & ~st_r.ack) begin
      st_nxt.rdata = rd_word;
    end

    // register writes
    if (wr_ctl3) begin
      st_nxt.ctl3 = avs_writedata[7:0];
    end
    if (wr_lo && idx == `ASC_IDX_MODE) begin
      st_nxt.mode = avs_writedata[2:0];
    end
    if (wr_start) begin
      st_nxt.start_ch = avs_writedata[3:0];
    end
    if (wr_lo && idx == `ASC_IDX_CMP) begin
      st_nxt.cmp_en = avs_writedata[7:0];
    end
    if (acc_wr && avs_byteenable[1] && idx == `ASC_IDX_CMP) begin
      st_nxt.cmp_ie = avs_writedata[`ASC_CMP_IE_BIT];
    end
    if (wr_lo && idx == `ASC_IDX_CCF) begin
      st_nxt.ccf = st_r.ccf & ~avs_writedata[7:0];
    end
    if (wr_lo && idx == `ASC_IDX_IRQ_MSK) begin
      st_nxt.irq_msk = avs_writedata[1:0];
    end
    // read clears, a new event in the same cycle survives
    st_nxt.irq_st = ((acc_rd && idx == `ASC_IDX_IRQ_ST) ? 2'h0 : st_r.irq_st) | irq_ev;

    // sequencer; wait mode has no input, so run and wait are alike
    case (st_r.state)
      asc_pkg::ASC_IDLE: begin
      end
      asc_pkg::ASC_ARMED: begin
        if (trig_rise) begin
          st_nxt.seq_idx = 4'h0;
          st_nxt.state   = asc_pkg::ASC_ISSUE;
        end
      end
      asc_pkg::ASC_ISSUE: begin
        if (freeze_mode && frz[1]) begin
          st_nxt.state = asc_pkg::ASC_HALT;
        end else begin
          st_nxt.conv_start = 1'b1;
          st_nxt.chan       = st_r.start_ch + (mult ? st_r.seq_idx : 4'h0);
          st_nxt.state      = asc_pkg::ASC_BUSY;
        end
      end
      asc_pkg::ASC_BUSY: begin
        if (frz_stop_now) begin
          // the half-done sample is dropped, the same position runs again
          st_nxt.conv_abort = 1'b1;
          st_nxt.state      = asc_pkg::ASC_HALT;
        end else if (conv_done) begin
          st_nxt.res[slot[2:0]] = justify(conv_result, st_r.ctl3[`ASC_DJM_BIT]);
          st_nxt.ccf[slot[2:0]] = 1'b1;
          st_nxt.seq_idx        = st_r.seq_idx + 4'h1;
          if (last) begin
            st_nxt.seq_idx = 4'h0;
            if (ext_trigger_mode_enable) begin
              st_nxt.state = asc_pkg::ASC_ARMED;
            end else if (scan) begin
              st_nxt.state = asc_pkg::ASC_ISSUE;
            end else begin
              st_nxt.state = asc_pkg::ASC_IDLE;
            end
          end else if (freeze_mode && frz == `ASC_FRZ_FINISH) begin
            st_nxt.state = asc_pkg::ASC_HALT;
          end else begin
            st_nxt.state = asc_pkg::ASC_ISSUE;
          end
        end
      end
      asc_pkg::ASC_HALT: begin
        if (!freeze_mode) begin
          st_nxt.state = asc_pkg::ASC_ISSUE;
        end
      end
      default: begin
        st_nxt.state = asc_pkg::ASC_IDLE;
      end
    endcase

    // a fresh start clears the flags even against a completion
    if (restart) begin
      st_nxt.ccf       = 8'h00;
      st_nxt.seq_idx   = 4'h0;
      st_nxt.stop_pend = 1'b0;
      st_nxt.state     = ext_trigger_mode_enable ? asc_pkg::ASC_ARMED : asc_pkg::ASC_ISSUE;
      st_nxt.conv_start = 1'b0;                               // no stale pulse escapes a restart
      st_nxt.conv_abort = (st_r.state == asc_pkg::ASC_BUSY);
    end
    if (wr_start && stop_mode) begin
      st_nxt.stop_pend = 1'b1;
    end
    if (abort) begin
      st_nxt.conv_start = 1'b0;
      st_nxt.conv_abort = (st_r.state == asc_pkg::ASC_BUSY);
      st_nxt.seq_idx    = 4'h0;
      st_nxt.state      = asc_pkg::ASC_IDLE;
    end
    if (stop_rise) begin
      st_nxt.stop_pend = (st_r.state != asc_pkg::ASC_IDLE);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata   = st_r.rdata;
  assign conv_start     = st_r.conv_start;
  assign conv_abort     = st_r.conv_abort;
  assign conv_channel   = st_r.chan;
  assign cmp_irq_en_eff = st_r.cmp_ie & ~fifo;
  assign cmp_en_eff     = st_r.cmp_en & {8{~fifo}};
  assign irq            = |(st_r.irq_st & st_r.irq_msk);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic       chk_store_q;
  logic [2:0] chk_slot_q;
  logic [9:0] chk_data_q;
  logic       chk_djm_q;

  always_ff @(posedge clock) begin
    chk_store_q <= store & ~abort & ~sys_rst;
    chk_slot_q  <= slot[2:0];
    chk_data_q  <= conv_result;
    chk_djm_q   <= st_r.ctl3[`ASC_DJM_BIT];
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_stop_enter;
    $rose(stop_mode) && st_r.state != asc_pkg::ASC_IDLE && !wr_ctl3;
  endsequence
  sequence s_stop_leave;
    $fell(stop_mode) && st_r.stop_pend && !wr_ctl3;
  endsequence

  a_ctl3_abort: assert property (wr_ctl3 |=> st_r.state == asc_pkg::ASC_IDLE)
    else $error("control three write did not abort");
  a_start_clear: assert property (wr_start && !stop_mode && !wr_ctl3 |=> st_r.ccf == 8'h00 && slot == 4'h0)
    else $error("start did not clear flags and slot");
  a_start_arms: assert property (wr_start && !stop_mode && ext_trigger_mode_enable
    |=> st_r.state == asc_pkg::ASC_ARMED && !conv_start)
    else $error("start write with trigger enabled did not only arm");
  a_armed_hold: assert property (st_r.state == asc_pkg::ASC_ARMED && !trig_rise && !restart
    |=> st_r.state != asc_pkg::ASC_ISSUE && !conv_start)
    else $error("armed converter issued without a trigger");
  a_reset_len: assert property ($fell(sys_rst) |-> st_r.ctl3 == `ASC_CTL3_RST && seq_len == 5'h04)
    else $error("sequence length after reset is not four");
  a_fifo_nocmp: assert property (fifo |-> !cmp_irq_en_eff && cmp_en_eff == 8'h00)
    else $error("compare enabled in FIFO mode");
  a_stop_abort: assert property (s_stop_enter |=> st_r.state == asc_pkg::ASC_IDLE && st_r.stop_pend)
    else $error("stop did not abort the sequence");
  a_stop_restart: assert property (s_stop_leave |=> st_r.ccf == 8'h00 && st_r.state != asc_pkg::ASC_IDLE)
    else $error("no restart after stop");
  a_result_justify: assert property (chk_store_q |-> st_r.res[chk_slot_q] ==
                                     (chk_djm_q ? {6'h00, chk_data_q} : {chk_data_q, 6'h00}))
    else $error("result stored with wrong justification");
  a_freeze_stop: assert property (st_r.state == asc_pkg::ASC_BUSY && frz_stop_now && !abort && !restart
                                  |=> st_r.state == asc_pkg::ASC_HALT && conv_abort)
    else $error("immediate freeze did not halt");
  a_seq_slot_zero: assert property (seq_begin && !fifo |=> slot == 4'h0)
    else $error("non-FIFO sequence did not start at slot zero");

endmodule

//--- bench/asc_conv_model.sv
// Purpose: converter core stand-in, answers each start after a set delay
// Assumes: start, abort and channel are registered on the bus clock
// Notes:   result lines toggle outside the done pulse, so a late capture shows up
`timescale 1ns/1ps
module asc_conv_model (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       conv_start,
  input  wire logic       conv_abort,
  input  wire logic [3:0] conv_channel,
  input  wire logic [7:0] delay,
  output logic            conv_done,
  output logic      [9:0] conv_result
);
  logic       busy_r;
  logic [7:0] cnt_r;
  logic [3:0] ch_r;

  // ----------------------------------------------------------------
  // one conversion at a time; abort drops the one in flight
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    conv_done   <= 1'b0;
    conv_result <= sys_rst ? 10'h000 : ~conv_result;
    if (sys_rst || conv_abort) begin
      busy_r <= 1'b0;
    end else if (conv_start) begin
      busy_r <= 1'b1;
      cnt_r  <= delay;
      ch_r   <= conv_channel;
    end else if (busy_r && cnt_r == 8'h00) begin
      busy_r      <= 1'b0;
      conv_done   <= 1'b1;
      conv_result <= {ch_r, 6'h15};
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule

//--- bench/asc_seq_control_test.sv
// Purpose: self-checking bench of the sequence control
// Assumes: converter model answers after the delay set here
// Notes:   bus requests are held until waitrequest is seen low
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_seq_control_test;
  logic        clock;
  logic        sys_rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        stop_mode;
  logic        freeze_mode;
  logic        ext_trigger;
  logic        conv_done;
  logic [9:0]  conv_result;
  logic        conv_start;
  logic        conv_abort;
  logic [3:0]  conv_channel;
  logic        cmp_irq_en_eff;
  logic [7:0]  cmp_en_eff;
  logic        irq;
  logic [7:0]  delay;
  logic [31:0] q;
  int          mismatches;
  int          cmp_count;
  int          starts = 0;
  int          n0;

  asc_seq_control DUT (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode), .freeze_mode(freeze_mode),
    .ext_trigger(ext_trigger), .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_channel(conv_channel), .cmp_irq_en_eff(cmp_irq_en_eff),
    .cmp_en_eff(cmp_en_eff), .irq(irq));
  asc_conv_model core (.clock(clock), .sys_rst(sys_rst), .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_channel(conv_channel), .delay(delay), .conv_done(conv_done), .conv_result(conv_result));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (conv_start === 1'b1) starts <= starts + 1;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [9:0] res(input logic [3:0] ch);
    return {ch, 6'h15};
  endfunction
  task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] d);
    @(posedge clock);
    avs_address   <= {i, 2'h0};
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [5:0] i, input logic [31:0] exp);
    bus(1'b0, i, 32'h0);
    chk(q, exp);
  endtask
  // polls without counting; a hang is cut by the watchdog
  task automatic wait_reg(input logic [5:0] i, input logic [31:0] m, input logic [31:0] v);
    do bus(1'b0, i, 32'h0); while ((q & m) !== v);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #600000;
    mismatches++;
    stop_test;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {avs_address, avs_read, avs_write, avs_writedata, stop_mode, freeze_mode, ext_trigger} = '0;
    sys_rst = 1'b1;
    delay = 8'h02;
    mismatches = 0;
    cmp_count = 0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    rchk(`ASC_IDX_CTL3, 32'h20);
    rchk(`ASC_IDX_STAT0, 32'h0);
    rchk(6'h02, 32'h0);
    $display("reset test done");
    bus(1'b1, `ASC_IDX_IRQ_MSK, 32'h1);
    bus(1'b1, `ASC_IDX_CTL3, 32'h90);
    bus(1'b1, `ASC_IDX_START, 32'h9);
    wait_reg(`ASC_IDX_STAT0, 32'h100, 32'h0);
    rchk({`ASC_IDX_RES_HI, 3'h0}, {22'h0, res(4'h9)});
    rchk({`ASC_IDX_RES_HI, 3'h1}, {22'h0, res(4'h9)});
    rchk(`ASC_IDX_CCF, 32'h3);
    rchk(`ASC_IDX_STAT0, 32'h0);
    chk(irq, 1'b1);
    rchk(`ASC_IDX_IRQ_ST, 32'h1);
    @(negedge clock);
    chk(irq, 1'b0);
    delay <= 8'h14;
    bus(1'b1, `ASC_IDX_IRQ_MSK, 32'h0);
    bus(1'b1, `ASC_IDX_CTL3, 32'h10);
    bus(1'b1, `ASC_IDX_MODE, 32'h2);
    bus(1'b1, `ASC_IDX_START, 32'hF);
    rchk(`ASC_IDX_CCF, 32'h0);
    wait_reg(`ASC_IDX_STAT0, 32'h100, 32'h0);
    rchk({`ASC_IDX_RES_HI, 3'h0}, {16'h0, res(4'hF), 6'h0});
    rchk({`ASC_IDX_RES_HI, 3'h1}, {16'h0, res(4'h0), 6'h0});
    chk(irq, 1'b0);
    rchk(`ASC_IDX_IRQ_ST, 32'h1);
    bus(1'b1, `ASC_IDX_CMP, 32'h1FF);
    @(negedge clock);
    chk({cmp_irq_en_eff, cmp_en_eff}, 32'h1FF);
    bus(1'b1, `ASC_IDX_CTL3, 32'h14);
    @(negedge clock);
    chk({cmp_irq_en_eff, cmp_en_eff}, 32'h0);
    $display("sequence test done");
    bus(1'b1, `ASC_IDX_CTL3, 32'h24);
    bus(1'b1, `ASC_IDX_START, 32'h0);
    repeat (30) @(posedge clock);
    rchk(`ASC_IDX_STAT0, 32'h101);
    bus(1'b1, `ASC_IDX_CTL3, 32'h24);
    rchk(`ASC_IDX_STAT0, 32'h0);
    rchk(`ASC_IDX_CCF, 32'h1);
    bus(1'b1, `ASC_IDX_CTL3, 32'h20);
    bus(1'b1, `ASC_IDX_START, 32'h0);
    repeat (30) @(posedge clock);
    stop_mode <= 1'b1;
    repeat (2) @(posedge clock);
    n0 = starts;
    repeat (60) @(posedge clock);
    chk(starts - n0, 0);
    stop_mode <= 1'b0;
    n0 = starts;
    rchk(`ASC_IDX_CCF, 32'h0);
    wait_reg(`ASC_IDX_STAT0, 32'h100, 32'h0);
    chk(starts - n0, 4);
    rchk(`ASC_IDX_CCF, 32'hF);
    $display("abort test done");
    bus(1'b1, `ASC_IDX_MODE, 32'h0);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `ASC_IDX_CTL3, 32'h90 | k);
      bus(1'b1, `ASC_IDX_START, 32'h7);
      repeat (5) @(posedge clock);
      freeze_mode <= 1'b1;
      repeat (60) @(posedge clock);
      rchk(`ASC_IDX_CCF, (k < 2) ? 32'h3 : (k == 2) ? 32'h1 : 32'h0);
      freeze_mode <= 1'b0;
      wait_reg(`ASC_IDX_STAT0, 32'h100, 32'h0);
      rchk(`ASC_IDX_CCF, 32'h3);
    end
    $display("freeze test done");
    delay <= 8'h02;
    bus(1'b1, `ASC_IDX_MODE, 32'h1);
    bus(1'b1, `ASC_IDX_CTL3, 32'h88);
    bus(1'b1, `ASC_IDX_START, 32'h3);
    repeat (100) @(posedge clock);
    rchk(`ASC_IDX_STAT0, 32'h100);
    rchk({`ASC_IDX_RES_HI, 3'h0}, {22'h0, res(4'h3)});
    bus(1'b1, `ASC_IDX_CTL3, 32'h94);
    bus(1'b1, `ASC_IDX_MODE, 32'h6);
    bus(1'b1, `ASC_IDX_START, 32'h5);
    n0 = starts;
    repeat (30) @(posedge clock);
    chk(starts - n0, 0);
    bus(1'b0, `ASC_IDX_IRQ_ST, 32'h0);
    for (int k = 0; k < 5; k++) begin
      ext_trigger <= 1'b1;
      repeat (4) @(posedge clock);
      ext_trigger <= 1'b0;
      wait_reg(`ASC_IDX_IRQ_ST, 32'h1, 32'h1);
    end
    rchk(`ASC_IDX_STAT0, 32'h102);
    rchk({`ASC_IDX_RES_HI, 3'h3}, {22'h0, res(4'h6)});
    rchk({`ASC_IDX_RES_HI, 3'h0}, {22'h0, res(4'h5)});
    rchk(`ASC_IDX_CCF, 32'hFF);
    $display("trigger test done");
    stop_test;
  end
endmodule
